// ==== hw/lpcu_defines.svh ====
// register offsets, bit positions, codes and reset values of the primitive command unit
`ifndef LPCU_DEFINES_SVH
`define LPCU_DEFINES_SVH
// register offsets
`define LPCU_CMD_OFS 4'h0
`define LPCU_CTL_OFS 4'h1
// command register fields
`define LPCU_ERR_BIT 15
`define LPCU_VALID_BIT 14
`define LPCU_PARM_HI 13
`define LPCU_PARM_LO 12
`define LPCU_CODE_HI 11
`define LPCU_CODE_LO 8
// control and status register fields
`define LPCU_IEN_BIT 0
`define LPCU_TDIS_BIT 1
`define LPCU_STOP_BIT 2
`define LPCU_INIT_BIT 3
`define LPCU_TXACT_BIT 4
`define LPCU_PH_LO 5
`define LPCU_PH_HI 6
`define LPCU_FLG_LO 8
`define LPCU_FLG_HI 11
// primitive codes
`define LPCU_PRIM_STOP 4'h0
`define LPCU_PRIM_START 4'h1
`define LPCU_PRIM_INIT 4'h2
`define LPCU_PRIM_TRANSP 4'h3
`define LPCU_PRIM_STATUS 4'h4
`define LPCU_PRIM_SELF 4'h5
// reset values
`define LPCU_STOP_RST 1'b1
`define LPCU_TXD_RST 1'b1
`define LPCU_RDATA_RST 16'h0000
`endif

// ==== hw/lpcu_pkg.sv ====
// types of the primitive command unit
package lpcu_pkg;
  typedef enum logic [1:0] {
    LPCU_PH_STOPPED = 2'b00,
    LPCU_PH_INFO = 2'b01,
    LPCU_PH_TRANSP = 2'b10
  } lpcu_phase_t;
  typedef enum logic [0:0] {
    LPCU_ST_IDLE = 1'b0,
    LPCU_ST_WAIT = 1'b1
  } lpcu_fsm_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } lpcu_bus_t;
  typedef struct packed {
    logic err;
    logic valid;
    logic [1:0] parm;
    logic [3:0] code;
  } lpcu_cmd_t;
  typedef struct packed {
    lpcu_cmd_t cmd;
    lpcu_phase_t phase;
    lpcu_fsm_t fsm;
    logic stop_st;
    logic init_done;
    logic ien;
    logic tdis;
    logic tx_active;
    logic [3:0] flags;
    logic [15:0] rdata;
    logic init_fetch;
    logic status_dump;
    logic self_test;
    logic ctx_reset;
    logic txd;
    logic rxd;
    logic rxd_valid;
  } lpcu_state_t;
endpackage

// ==== hw/lpcu_top.sv ====
// primitive command unit: command register, primitive decoder and phase control
//
// Operation
// - conflicting primitive sets the error flag in bit 15.
// - writing one clears the error flag; zero keeps it; reset clears it.
// - host sets valid bit 14; device clears it when done; reset clears.
// - stop enters stopped phase, ends link activity, sets stop status, halts DMA; this unit halts no job, and a stop written while a job runs is dropped.
// - stopped phase sends all ones and drops received data.
// - start only when stopped and initialised, else an error.
// - without auto LMI, LMI frames go only on host request.
// - init request fetches the init block, only when stopped.
// - transparent phase routes every received frame to context entry zero.
// - transparent phase may transmit from any context entry.
// - status request writes status buffer, any phase, after init.
// - self test runs only in the stopped phase.
// - start with transmit disable clear sets transmitter active; stop clears it.
// - stop clears interrupt enable and interrupt-causing flags.
//
// The strobed register port and the address map are this design's own decisions.
`include "lpcu_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module lpcu_top import lpcu_pkg::*; #(
  parameter int FLAG_N = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire lpcu_bus_t i_bus,
  output logic [15:0] o_rdata,
  // memory and self test jobs
  output logic o_init_fetch,
  output logic o_status_dump,
  output logic o_self_test,
  input wire logic i_job_done,
  // link and channel control
  output lpcu_phase_t o_phase,
  output logic o_stop_status,
  output logic o_ctx_reset,
  output logic o_tx_active,
  output logic o_ien,
  output logic [3:0] o_flags,
  input wire logic [3:0] i_flag_event,
  // serial data
  input wire logic i_tx_data,
  output logic o_txd,
  input wire logic i_rx_data,
  input wire logic i_rx_valid,
  output logic o_rxd,
  output logic o_rxd_valid
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (FLAG_N < 1 || FLAG_N > 4) begin : g_bad_flag_n
    $error("FLAG_N must lie between 1 and 4");
  end

  // ****************************************
  // state
  // ****************************************
  lpcu_state_t s;
  lpcu_state_t next_s;
  logic [3:0] evt;
  logic proc;
  logic wr_cmd;
  logic wr_ctl;
  logic ok;

  // events beyond FLAG_N are not wired to any flag
  assign evt = i_flag_event & ((4'h1 << FLAG_N) - 4'h1);
  // a primitive is decoded only while the engine is free
  assign proc = s.cmd.valid && (s.fsm == LPCU_ST_IDLE);
  assign wr_cmd = i_bus.wr && (i_bus.addr == `LPCU_CMD_OFS);
  assign wr_ctl = i_bus.wr && (i_bus.addr == `LPCU_CTL_OFS);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    ok = 1'b1;
    next_s.init_fetch = 1'b0;
    next_s.status_dump = 1'b0;
    next_s.self_test = 1'b0;
    next_s.ctx_reset = 1'b0;
    next_s.rdata = `LPCU_RDATA_RST;
    // serial path: idle ones and deaf receiver while stopped
    next_s.txd = (s.phase == LPCU_PH_STOPPED) ? 1'b1 : i_tx_data;
    next_s.rxd_valid = i_rx_valid && (s.phase != LPCU_PH_STOPPED);
    next_s.rxd = i_rx_data;
    // control register writes
    if (wr_ctl) begin
      // interrupt enable cannot be raised in the stopped phase
      next_s.ien = i_bus.wdata[`LPCU_IEN_BIT] && (s.phase != LPCU_PH_STOPPED);
      next_s.tdis = i_bus.wdata[`LPCU_TDIS_BIT];
      next_s.flags = s.flags & ~i_bus.wdata[`LPCU_FLG_HI:`LPCU_FLG_LO];
      if (i_bus.wdata[`LPCU_TDIS_BIT]) begin
        next_s.tx_active = 1'b0;
      end else if (s.tdis && s.phase != LPCU_PH_STOPPED) begin
        next_s.tx_active = 1'b1;
      end
    end
    // command register writes
    if (wr_cmd) begin
      if (i_bus.wdata[`LPCU_ERR_BIT]) begin
        next_s.cmd.err = 1'b0;
      end
      // a new primitive written while one is pending is dropped; the error clear still acts
      if (i_bus.wdata[`LPCU_VALID_BIT] && !s.cmd.valid) begin
        next_s.cmd.valid = 1'b1;
        next_s.cmd.parm = i_bus.wdata[`LPCU_PARM_HI:`LPCU_PARM_LO];
        next_s.cmd.code = i_bus.wdata[`LPCU_CODE_HI:`LPCU_CODE_LO];
      end
    end
    // primitive decode
    if (proc) begin
      next_s.cmd.valid = 1'b0;
      case (s.cmd.code)
        `LPCU_PRIM_STOP: begin
          next_s.phase = LPCU_PH_STOPPED;
          next_s.stop_st = 1'b1;
          next_s.tx_active = 1'b0;
          next_s.ien = 1'b0;
          next_s.flags = 4'h0;
        end
        `LPCU_PRIM_START: begin
          ok = (s.phase == LPCU_PH_STOPPED) && s.init_done;
          if (ok) begin
            // no auto LMI here: LMI frames leave only on request
            next_s.phase = LPCU_PH_INFO;
            next_s.stop_st = 1'b0;
            next_s.ctx_reset = 1'b1;
            next_s.tx_active = !next_s.tdis;
          end
        end
        `LPCU_PRIM_INIT: begin
          ok = (s.phase == LPCU_PH_STOPPED);
          if (ok) begin
            next_s.init_fetch = 1'b1;
            next_s.fsm = LPCU_ST_WAIT;
            next_s.cmd.valid = 1'b1;
          end
        end
        `LPCU_PRIM_TRANSP: begin
          ok = (s.phase == LPCU_PH_STOPPED) && s.init_done;
          if (ok) begin
            // phase code steers rx to entry zero and tx from any entry
            next_s.phase = LPCU_PH_TRANSP;
            next_s.stop_st = 1'b0;
            next_s.ctx_reset = 1'b1;
            next_s.tx_active = !next_s.tdis;
          end
        end
        `LPCU_PRIM_STATUS: begin
          ok = s.init_done;
          if (ok) begin
            next_s.status_dump = 1'b1;
            next_s.fsm = LPCU_ST_WAIT;
            next_s.cmd.valid = 1'b1;
          end
        end
        `LPCU_PRIM_SELF: begin
          ok = (s.phase == LPCU_PH_STOPPED);
          if (ok) begin
            next_s.self_test = 1'b1;
            next_s.fsm = LPCU_ST_WAIT;
            next_s.cmd.valid = 1'b1;
          end
        end
        default: begin
          // codes above five are not served by this unit
          ok = 1'b0;
        end
      endcase
      if (!ok) begin
        next_s.cmd.err = 1'b1;
      end
    end else if (s.fsm == LPCU_ST_WAIT && i_job_done) begin
      next_s.cmd.valid = 1'b0;
      next_s.fsm = LPCU_ST_IDLE;
      if (s.cmd.code == `LPCU_PRIM_INIT) begin
        next_s.init_done = 1'b1;
      end
    end
    // new events win over a clear in the same cycle
    next_s.flags = next_s.flags | evt;
    // read data stand in the cycle after the strobe only
    if (i_bus.rd) begin
      if (i_bus.addr == `LPCU_CMD_OFS) begin
        next_s.rdata = {s.cmd, 8'h00};
      end else if (i_bus.addr == `LPCU_CTL_OFS) begin
        next_s.rdata[`LPCU_IEN_BIT] = s.ien;
        next_s.rdata[`LPCU_TDIS_BIT] = s.tdis;
        next_s.rdata[`LPCU_STOP_BIT] = s.stop_st;
        next_s.rdata[`LPCU_INIT_BIT] = s.init_done;
        next_s.rdata[`LPCU_TXACT_BIT] = s.tx_active;
        next_s.rdata[`LPCU_PH_HI:`LPCU_PH_LO] = s.phase;
        next_s.rdata[`LPCU_FLG_HI:`LPCU_FLG_LO] = s.flags;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s <= '0;
      s.stop_st <= `LPCU_STOP_RST;
      s.txd <= `LPCU_TXD_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs are state fields
  assign o_rdata = s.rdata;
  assign o_init_fetch = s.init_fetch;
  assign o_status_dump = s.status_dump;
  assign o_self_test = s.self_test;
  assign o_phase = s.phase;
  assign o_stop_status = s.stop_st;
  assign o_ctx_reset = s.ctx_reset;
  assign o_tx_active = s.tx_active;
  assign o_ien = s.ien;
  assign o_flags = s.flags;
  assign o_txd = s.txd;
  assign o_rxd = s.rxd;
  assign o_rxd_valid = s.rxd_valid;

  // ****************************************
  // assertions
  // ****************************************
  a_self_conflict: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_SELF && s.phase != LPCU_PH_STOPPED
    |=> s.cmd.err && !s.cmd.valid)
    else $error("self test outside stopped phase not flagged");
  a_err_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s.cmd.err && !(wr_cmd && i_bus.wdata[`LPCU_ERR_BIT]) |=> s.cmd.err)
    else $error("error flag lost without a clear");
  a_err_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_cmd && i_bus.wdata[`LPCU_ERR_BIT] && !proc |=> !s.cmd.err)
    else $error("error flag not cleared by writing one");
  a_job_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s.fsm == LPCU_ST_WAIT && i_job_done |=> !s.cmd.valid ##1 s.fsm == LPCU_ST_IDLE)
    else $error("valid flag not released after job");
  a_stop_effect: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_STOP
    |=> s.phase == LPCU_PH_STOPPED && s.stop_st && !s.tx_active && !s.ien)
    else $error("stop primitive did not stop");
  a_stopped_line: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s.phase == LPCU_PH_STOPPED |=> o_txd && !o_rxd_valid)
    else $error("line active in stopped phase");
  a_start_ok: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_START && s.phase == LPCU_PH_STOPPED && s.init_done
    |=> s.phase == LPCU_PH_INFO && o_ctx_reset ##1 !o_ctx_reset)
    else $error("start not taken");
  a_start_early: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_START && !s.init_done
    |=> s.cmd.err && s.phase == LPCU_PH_STOPPED)
    else $error("start before init not rejected");
  a_init_job: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_INIT && s.phase == LPCU_PH_STOPPED
    |=> o_init_fetch && s.cmd.valid && s.fsm == LPCU_ST_WAIT)
    else $error("init fetch not issued");
  a_transp_ok: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_TRANSP && s.phase == LPCU_PH_STOPPED && s.init_done
    |=> s.phase == LPCU_PH_TRANSP && o_ctx_reset)
    else $error("transparent not taken");
  a_status_early: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_STATUS && !s.init_done |=> s.cmd.err && !o_status_dump)
    else $error("status request before init not rejected");
  a_reject_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && !ok |=> s.phase == $past(s.phase) && !s.cmd.valid)
    else $error("rejected primitive changed phase");
  a_high_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code > `LPCU_PRIM_SELF |=> s.cmd.err && !s.cmd.valid)
    else $error("unserved primitive code not flagged");
  a_stop_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_STOP && evt == 4'h0 |=> o_flags == 4'h0 && !o_ien)
    else $error("stop left interrupt state set");
  a_transp_early: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_TRANSP && !s.init_done
    |=> s.cmd.err && s.phase == LPCU_PH_STOPPED)
    else $error("transparent before init not rejected");
  a_tx_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    proc && s.cmd.code == `LPCU_PRIM_START && s.phase == LPCU_PH_STOPPED && s.init_done
    && !s.tdis && !wr_ctl |=> o_tx_active)
    else $error("transmitter not active after start");
  a_job_pending: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s.fsm == LPCU_ST_WAIT && !i_job_done |=> s.cmd.valid && s.fsm == LPCU_ST_WAIT)
    else $error("valid flag dropped before job end");

endmodule

`default_nettype wire

// ==== bench/lpcu_job_model.sv ====
// memory and self test job responder standing beside the command unit
`timescale 1ns/1ns
`default_nettype none

// ********************************
// job responder
// ********************************
module lpcu_job_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // job request and pace
  input wire logic i_start,
  input wire logic i_slow,
  // completion pulse
  output logic o_done
);
  logic [3:0] cnt;

  // finish a started job after a short or long wait
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt == 4'h1);
      if (i_start) begin
        cnt <= i_slow ? 4'h8 : 4'h2;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ==== bench/lpcu_tb.sv ====
// self-checking bench of the primitive command unit
`timescale 1ns/1ns
`default_nettype none

// ********************************
// bench top
// ********************************
module lpcu_tb import lpcu_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rst_n, slow, tx, rx, rxv, done;
  logic init_f, stat_d, self_t, ctx_r, txd, rxd, rxdv, ien, txa, stp;
  logic [3:0] ev, flg;
  logic [15:0] rdata, r;
  lpcu_bus_t bus;
  lpcu_phase_t ph;
  int error_cnt = 0;
  int cmp_count = 0;
  int n_init = 0, n_stat = 0, n_self = 0, n_ctx = 0;

  // 20 MHz clock
  always #25 i_clk = ~i_clk;

  lpcu_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
    .o_init_fetch(init_f), .o_status_dump(stat_d), .o_self_test(self_t),
    .i_job_done(done), .o_phase(ph), .o_stop_status(stp), .o_ctx_reset(ctx_r),
    .o_tx_active(txa), .o_ien(ien), .o_flags(flg), .i_flag_event(ev),
    .i_tx_data(tx), .o_txd(txd), .i_rx_data(rx), .i_rx_valid(rxv),
    .o_rxd(rxd), .o_rxd_valid(rxdv));

  lpcu_job_model job (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_start(init_f | stat_d | self_t), .i_slow(slow), .o_done(done));

  // count one-cycle job and context pulses
  always @(posedge i_clk) begin
    if (init_f === 1'b1) n_init++;
    if (stat_d === 1'b1) n_stat++;
    if (self_t === 1'b1) n_self++;
    if (ctx_r === 1'b1) n_ctx++;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes are one cycle, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask

  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // issue a primitive, poll until valid drops, check the error outcome
  task automatic pe(input logic [3:0] c, input logic e);
    int i;
    wr(4'h0, {4'h4, c, 8'h00});
    r = 16'h4000;
    for (i = 0; i < 40 && r[14] !== 1'b0; i++) rd(4'h0, r);
    chk(r & 16'hc000, e ? 16'h8000 : 16'h0000);
    if (e) begin
      wr(4'h0, 16'h0000);
      rd(4'h0, r);
      chk(r & 16'h8000, 16'h8000);
      wr(4'h0, 16'h8000);
      rd(4'h0, r);
      chk(r & 16'h8000, 16'h0000);
    end
  endtask

  // watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    wrap_up;
  end

  // test sequence
  initial begin
    bus = '0;
    i_rst_n = 1'b0;
    slow = 1'b0;
    tx = 1'b1;
    rx = 1'b0;
    rxv = 1'b0;
    ev = 4'h0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(4'h0, r);
    chk(r, 16'h0000);
    rd(4'h1, r);
    chk(r, 16'h0004);
    pe(4'h1, 1'b1);
    pe(4'h3, 1'b1);
    pe(4'h4, 1'b1);
    chk({14'h0, ph}, 16'h0000);
    pe(4'h5, 1'b0);
    chk(16'(n_self), 16'h0001);
    slow <= 1'b1;
    pe(4'h2, 1'b0);
    chk(16'(n_init), 16'h0001);
    rd(4'h1, r);
    chk(r & 16'h0008, 16'h0008);
    wr(4'h1, 16'h0001);
    tx <= 1'b0;
    rxv <= 1'b1;
    rx <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk({ien, txd, rxdv}, 16'h0002);
    pe(4'h1, 1'b0);
    repeat (2) @(posedge i_clk);
    chk({ph, txa, stp, txd, rxdv}, 16'h0019);
    chk({15'h0, rxd}, 16'h0001);
    chk(16'(n_ctx), 16'h0001);
    pe(4'h2, 1'b1);
    pe(4'h5, 1'b1);
    pe(4'h1, 1'b1);
    pe(4'h3, 1'b1);
    chk({14'h0, ph}, 16'h0001);
    slow <= 1'b0;
    pe(4'h4, 1'b0);
    chk(16'(n_stat), 16'h0001);
    wr(4'h1, 16'h0001);
    @(posedge i_clk);
    ev <= 4'h5;
    @(posedge i_clk);
    ev <= 4'h0;
    repeat (2) @(posedge i_clk);
    chk({ien, flg}, 16'h0015);
    pe(4'h0, 1'b0);
    repeat (2) @(posedge i_clk);
    chk({ph, stp, txa, ien, flg, txd, rxdv}, 16'h0102);
    pe(4'h3, 1'b0);
    chk({14'h0, ph}, 16'h0002);
    chk(16'(n_ctx), 16'h0002);
    pe(4'h4, 1'b0);
    chk(16'(n_stat), 16'h0002);
    pe(4'h0, 1'b0);
    wr(4'h0, 16'h4600);
    repeat (2) @(posedge i_clk);
    rd(4'h0, r);
    chk(r & 16'hc000, 16'h8000);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(4'h0, r);
    chk(r, 16'h0000);
    rd(4'h1, r);
    chk(r, 16'h0004);
    rd(4'h5, r);
    chk(r, 16'h0000);
    wrap_up;
  end
endmodule

`default_nettype wire
